//--- hdl/dcc_defines.vh
// Constants for the core control register block.
`ifndef DCC_DEFINES_VH
`define DCC_DEFINES_VH
`define DCC_ADDR_W 12
`define DCC_ADDR_IFACE_LO 12'h800
`define DCC_ADDR_IFACE_HI 12'h807
`define DCC_ADDR_PIN_SET 12'h808
`define DCC_ADDR_AUX_LO 12'h809
`define DCC_ADDR_AUX_HI 12'h80C
`define DCC_ADDR_CORE_CTRL 12'h81C
`define DCC_ADDR_SL_DATA_LO 12'h810
`define DCC_ADDR_SL_ADDR_LO 12'h815
`define DCC_CTRL_RESET 16'h0000
`define DCC_CTRL_WMASK 16'h31FF
`define DCC_BIT_RATE_LO 0
`define DCC_BIT_RELEASE 2
`define DCC_BIT_DAC_UNMUTE 3
`define DCC_BIT_ADC_UNMUTE 4
`define DCC_BIT_SL_START 5
`define DCC_BIT_IFACE_HW 6
`define DCC_BIT_PIN_HW 7
`define DCC_BIT_AUX_HW 8
`define DCC_BIT_DEB_LO 12
`define DCC_RATE_1X 2'b00
`define DCC_RATE_2X 2'b01
`define DCC_RATE_4X 2'b10
`define DCC_INSTR_1X 11'h400
`define DCC_INSTR_2X 11'h200
`define DCC_INSTR_4X 11'h100
`define DCC_CLK_HZ 40000000
`define DCC_DEB_MS_00 20
`define DCC_DEB_MS_01 40
`define DCC_DEB_MS_10 10
`define DCC_DEB_MS_11 5
`define DCC_SL_PAIRS 5
`endif

//--- hdl/dcc_safeload.v
// Safeload staging pairs with written flags and a sequencer that copies them out.
`timescale 1ns/100ps
`default_nettype none
module dcc_safeload #(
  parameter PAIRS = 5,
  parameter AW = 10,
  parameter DW = 28
) (
  input wire clk,
  input wire reset_n,
  input wire wrAddrEn,
  input wire wrDataEn,
  input wire [2:0] wrIdx,
  input wire [15:0] wrValue,
  input wire start,
  output reg busy_r,
  output reg ramWe_r,
  output reg [AW-1:0] ramAddr_r,
  output reg [DW-1:0] ramData_r
);
  localparam ST_IDLE = 1'b0;
  localparam ST_COPY = 1'b1;
  reg [AW-1:0] slAddr [0:PAIRS-1];
  reg [DW-1:0] slData [0:PAIRS-1];
  reg [PAIRS-1:0] written_r;
  reg [2:0] idx_r;
  reg state_r;
  integer i;

  // Staging pairs: the host fills them, each write marks its pair as pending.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < PAIRS; i = i + 1) begin
        slAddr[i] <= {AW{1'b0}};
        slData[i] <= {DW{1'b0}};
      end
    end else begin
      if (wrAddrEn && wrIdx < PAIRS) begin
        slAddr[wrIdx] <= wrValue[AW-1:0];
      end
      if (wrDataEn && wrIdx < PAIRS) begin
        slData[wrIdx] <= {{(DW-16){wrValue[15]}}, wrValue};
      end
    end
  end

  // Sequencer walks pending pairs; a flag set at or after its pair's turn in the walk is kept for next time.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      idx_r <= 3'h0;
      written_r <= {PAIRS{1'b0}};
      busy_r <= 1'b0;
      ramWe_r <= 1'b0;
      ramAddr_r <= {AW{1'b0}};
      ramData_r <= {DW{1'b0}};
    end else begin
      ramWe_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_COPY;
            busy_r <= 1'b1;
            idx_r <= 3'h0;
          end
        end
        default: begin
          if (written_r[idx_r]) begin
            ramWe_r <= 1'b1;
            ramAddr_r <= slAddr[idx_r];
            ramData_r <= slData[idx_r];
          end
          if (idx_r == PAIRS - 1) begin
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
          end
          idx_r <= idx_r + 3'h1;
        end
      endcase
      for (i = 0; i < PAIRS; i = i + 1) begin
        if ((wrAddrEn || wrDataEn) && wrIdx == i) begin
          written_r[i] <= 1'b1;
        end else if (state_r == ST_COPY && idx_r == i) begin
          written_r[i] <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/dcc_core_control.v
// Core control register with override modes, safeload start, mutes and rate select.
`timescale 1ns/100ps
`default_nettype none
`include "dcc_defines.vh"
module dcc_core_control #(
  parameter CLK_HZ = `DCC_CLK_HZ,
  parameter NPINS = 12
) (
  input wire clk,
  input wire reset_n,
  input wire hostWr,
  input wire hostRd,
  input wire [11:0] hostAddr,
  input wire [15:0] hostWdata,
  output reg [15:0] hostRdata_r,
  input wire progIfaceWe,
  input wire [2:0] progIfaceIdx,
  input wire [15:0] progIfaceData,
  input wire [NPINS-1:0] mpPins,
  input wire [15:0] auxAdcIn,
  output reg [127:0] ifaceRegs_r,
  output reg [NPINS-1:0] pinSetting_r,
  output reg [63:0] auxData_r,
  output reg adcMute_r,
  output reg dacMute_r,
  output reg coreClear_r,
  output reg [10:0] instrPerSample_r,
  output reg slRamWe_r,
  output reg [9:0] slRamAddr_r,
  output reg [27:0] slRamData_r
);
  // Debounce hold times in clock cycles, one per debounce code.
  localparam [31:0] T20 = CLK_HZ / 1000 * `DCC_DEB_MS_00;
  localparam [31:0] T40 = CLK_HZ / 1000 * `DCC_DEB_MS_01;
  localparam [31:0] T10 = CLK_HZ / 1000 * `DCC_DEB_MS_10;
  localparam [31:0] T05 = CLK_HZ / 1000 * `DCC_DEB_MS_11;

  // Stored control bits, synchroniser stages and the shared debounce counter.
  reg [15:0] ctrl_r;
  reg [NPINS-1:0] pinMeta_r, pinSync_r, pinStable_r, pinDeb_r;
  reg [31:0] debCnt_r;
  reg [63:0] auxMeta_r, auxSync_r;
  // Host decodes and control field taps shared by the processes below.
  wire slBusy, slWe;
  wire [9:0] slAddr;
  wire [27:0] slData;
  wire ctrlWr = hostWr && hostAddr == `DCC_ADDR_CORE_CTRL;
  wire slStart = ctrlWr && hostWdata[`DCC_BIT_SL_START] && !slBusy;
  wire [1:0] debSel = ctrl_r[`DCC_BIT_DEB_LO+1:`DCC_BIT_DEB_LO];
  wire [1:0] rateSel = ctrl_r[`DCC_BIT_RATE_LO+1:`DCC_BIT_RATE_LO];
  wire slAddrWr = hostWr && hostAddr >= `DCC_ADDR_SL_ADDR_LO
    && hostAddr < `DCC_ADDR_SL_ADDR_LO + 12'h005;
  wire slDataWr = hostWr && hostAddr >= `DCC_ADDR_SL_DATA_LO
    && hostAddr < `DCC_ADDR_SL_DATA_LO + 12'h005;
  wire [2:0] slIdx = slAddrWr ? hostAddr[2:0] - 3'h5 : hostAddr[2:0];

  // The aux word index stays two bits wide, so location 2060 wraps to word three.
  wire [1:0] auxIdx = hostAddr[1:0] - 2'b01;

  // Decodes the debounce code into a hold time in clock cycles.
  function [31:0] debLimit;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: debLimit = T20;
        2'b01: debLimit = T40;
        2'b10: debLimit = T10;
        default: debLimit = T05;
      endcase
    end
  endfunction

  // Control register; the start bit reads as the live busy state.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= `DCC_CTRL_RESET;
    end else if (ctrlWr) begin
      ctrl_r <= hostWdata & `DCC_CTRL_WMASK & ~(16'h0001 << `DCC_BIT_SL_START);
    end
  end

  // Pin inputs pass two flip-flops, then must hold steady for the debounce time.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta_r <= {NPINS{1'b0}};
      pinSync_r <= {NPINS{1'b0}};
      pinStable_r <= {NPINS{1'b0}};
      pinDeb_r <= {NPINS{1'b0}};
      debCnt_r <= 32'h0000_0000;
      auxMeta_r <= 64'h0000_0000_0000_0000;
      auxSync_r <= 64'h0000_0000_0000_0000;
    end else begin
      pinMeta_r <= mpPins;
      pinSync_r <= pinMeta_r;
      auxMeta_r <= {4{auxAdcIn}};
      auxSync_r <= auxMeta_r;
      pinStable_r <= pinSync_r;
      // One counter serves all pins, so any change restarts the hold for every pin.
      if (pinSync_r != pinStable_r) begin
        debCnt_r <= 32'h0000_0000;
      end else if (debCnt_r >= debLimit(debSel)) begin
        pinDeb_r <= pinStable_r;
      end else begin
        debCnt_r <= debCnt_r + 32'h0000_0001;
      end
    end
  end

  // Interface, pin setting and aux registers take host or internal sources per mode.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ifaceRegs_r <= 128'h0;
      pinSetting_r <= {NPINS{1'b0}};
      auxData_r <= 64'h0000_0000_0000_0000;
    end else begin
      if (ctrl_r[`DCC_BIT_IFACE_HW]) begin
        if (hostWr && hostAddr >= `DCC_ADDR_IFACE_LO && hostAddr <= `DCC_ADDR_IFACE_HI) begin
          ifaceRegs_r[hostAddr[2:0]*16 +: 16] <= hostWdata;
        end
      end else if (progIfaceWe) begin
        ifaceRegs_r[progIfaceIdx*16 +: 16] <= progIfaceData;
      end
      if (ctrl_r[`DCC_BIT_PIN_HW]) begin
        if (hostWr && hostAddr == `DCC_ADDR_PIN_SET) begin
          pinSetting_r <= hostWdata[NPINS-1:0];
        end
      end else begin
        pinSetting_r <= pinDeb_r;
      end
      // Host writes reach the aux words only while the aux write bit is set.
      if (ctrl_r[`DCC_BIT_AUX_HW]) begin
        if (hostWr && hostAddr >= `DCC_ADDR_AUX_LO && hostAddr <= `DCC_ADDR_AUX_HI) begin
          auxData_r[auxIdx*16 +: 16] <= hostWdata;
        end
      end else begin
        auxData_r <= auxSync_r;
      end
    end
  end

  // Mutes, core clear and instruction count follow the control bits.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      adcMute_r <= 1'b1;
      dacMute_r <= 1'b1;
      coreClear_r <= 1'b1;
      instrPerSample_r <= `DCC_INSTR_1X;
    end else begin
      adcMute_r <= !ctrl_r[`DCC_BIT_ADC_UNMUTE];
      dacMute_r <= !ctrl_r[`DCC_BIT_DAC_UNMUTE];
      coreClear_r <= !ctrl_r[`DCC_BIT_RELEASE];
      // The reserved rate code falls back to the single-rate count.
      case (rateSel)
        `DCC_RATE_2X: instrPerSample_r <= `DCC_INSTR_2X;
        `DCC_RATE_4X: instrPerSample_r <= `DCC_INSTR_4X;
        default: instrPerSample_r <= `DCC_INSTR_1X;
      endcase
    end
  end

  // Read port; only the control register answers, others read zero.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hostRdata_r <= 16'h0000;
    end else if (hostRd && hostAddr == `DCC_ADDR_CORE_CTRL) begin
      hostRdata_r <= ctrl_r | ({15'h0000, slBusy | slStart} << `DCC_BIT_SL_START);
    end else begin
      hostRdata_r <= 16'h0000;
    end
  end

  // Safeload outputs are re-registered so every top output comes from a flop.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slRamWe_r <= 1'b0;
      slRamAddr_r <= 10'h000;
      slRamData_r <= 28'h000_0000;
    end else begin
      slRamWe_r <= slWe;
      slRamAddr_r <= slAddr;
      slRamData_r <= slData;
    end
  end

  // Safeload staging and copy sequencer; a start only reaches it while idle.
  dcc_safeload #(
    .PAIRS(`DCC_SL_PAIRS),
    .AW(10),
    .DW(28)
  ) dcc_safeload_inst (
    .clk(clk),
    .reset_n(reset_n),
    .wrAddrEn(slAddrWr),
    .wrDataEn(slDataWr),
    .wrIdx(slIdx),
    .wrValue(hostWdata),
    .start(slStart),
    .busy_r(slBusy),
    .ramWe_r(slWe),
    .ramAddr_r(slAddr),
    .ramData_r(slData)
  );
endmodule
`default_nettype wire

//--- bench/dcc_core_control_properties.sv
// Checker of the core control register port timing.
`timescale 1ns/100ps
`default_nettype none
`include "dcc_defines.vh"
module dcc_core_control_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hostWr,
  input wire logic hostRd,
  input wire logic [11:0] hostAddr,
  input wire logic [15:0] hostWdata,
  input wire logic [15:0] hostRdata_r,
  input wire logic progIfaceWe,
  input wire logic [127:0] ifaceRegs_r,
  input wire logic adcMute_r,
  input wire logic dacMute_r,
  input wire logic coreClear_r,
  input wire logic [10:0] instrPerSample_r,
  input wire logic slRamWe_r
);
  logic ctlWr, ctlRd, ifaceHw_r;
  logic [3:0] quiet_r;
  logic [4:0] since_r;
  logic [10:0] expInstr;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Decodes control accesses and the instruction count a write asks for.
  assign ctlWr = hostWr && hostAddr == `DCC_ADDR_CORE_CTRL;
  assign ctlRd = hostRd && hostAddr == `DCC_ADDR_CORE_CTRL;
  assign expInstr = hostWdata[1:0] == `DCC_RATE_2X ? `DCC_INSTR_2X :
    hostWdata[1:0] == `DCC_RATE_4X ? `DCC_INSTR_4X : `DCC_INSTR_1X;
  // Tracks interface mode, cycles without host writes and cycles since a start.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ifaceHw_r <= 1'b0;
      quiet_r <= 4'h0;
      since_r <= 5'h1F;
    end else begin
      if (ctlWr) ifaceHw_r <= hostWdata[6];
      quiet_r <= hostWr ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hF};
      since_r <= (ctlWr && hostWdata[5]) ? 5'h00 : since_r + {4'h0, since_r != 5'h1F};
    end
  end
  adc_mute_a:
    assert property (ctlWr |-> ##2 adcMute_r == !$past(hostWdata[4], 2)) else $error("adc mute");
  dac_mute_a:
    assert property (ctlWr |-> ##2 dacMute_r == !$past(hostWdata[3], 2)) else $error("dac mute");
  core_clear_a:
    assert property (ctlWr |-> ##2 coreClear_r == !$past(hostWdata[2], 2)) else $error("clear");
  rate_instr_a:
    assert property (ctlWr |-> ##2 instrPerSample_r == $past(expInstr, 2)) else $error("rate");
  rsvd_zero_a:
    assert property (ctlRd |=> (hostRdata_r & 16'hCE00) == 16'h0000) else $error("reserved");
  start_busy_a:
    assert property (ctlRd && since_r <= 5'h03 |=> hostRdata_r[5]) else $error("busy");
  start_clear_a:
    assert property (ctlRd && since_r >= 5'h06 |=> !hostRdata_r[5]) else $error("no clear");
  copy_after_start_a:
    assert property (slRamWe_r |-> since_r <= 5'd12) else $error("stray copy");
  prog_blocked_a:
    assert property (progIfaceWe && ifaceHw_r && !hostWr && quiet_r >= 4'd3 |=>
      $stable(ifaceRegs_r)) else $error("program write taken");
  cover property (ctlWr && hostWdata[5]);
  cover property (slRamWe_r);
  cover property (progIfaceWe && ifaceHw_r);
endmodule
bind dcc_core_control dcc_core_control_properties dcc_core_control_properties_inst (.clk,
  .reset_n, .hostWr, .hostRd, .hostAddr, .hostWdata, .hostRdata_r, .progIfaceWe, .ifaceRegs_r,
  .adcMute_r, .dacMute_r, .coreClear_r, .instrPerSample_r, .slRamWe_r);
`default_nettype wire

//--- bench/dcc_host_model.sv
// Host controller model driving the control port with one-cycle strobes.
`timescale 1ns/100ps
`default_nettype none
`include "dcc_defines.vh"
module dcc_host_model (
  input wire logic clk,
  input wire logic [15:0] hostRdata_r,
  output logic hostWr = 1'b0,
  output logic hostRd = 1'b0,
  output logic [11:0] hostAddr = 12'h000,
  output logic [15:0] hostWdata = 16'h0000
);
  // One write; the released bus parks inverted so stale values never look valid.
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 {hostWr, hostAddr, hostWdata} = {1'b1, a, d};
    @(posedge clk);
    #1 {hostWr, hostAddr, hostWdata} = {1'b0, ~a, ~d};
  endtask
  // One read; the registered answer is taken just after the accepting edge.
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge clk);
    #1 {hostRd, hostAddr} = {1'b1, a};
    @(posedge clk);
    #1 {hostRd, hostAddr} = {1'b0, ~a};
    d = hostRdata_r;
  endtask
  // Polls the start bit, up to 20 reads, until it reads 0, so no transfer overlaps another.
  task automatic wait_idle(output logic ok);
    logic [15:0] v;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      rd(`DCC_ADDR_CORE_CTRL, v);
      ok = v[5] === 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- bench/test_dcc_core_control.sv
// Self-checking bench for the core control register block.
`timescale 1ns/100ps
`default_nettype none
`include "dcc_defines.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module test_dcc_core_control;
  localparam logic [11:0] CTL = `DCC_ADDR_CORE_CTRL;
  localparam int HZ = 4000;
  logic clk = 1'b0, reset_n = 1'b0, pWe = 1'b0, ok;
  logic hostWr, hostRd, adcMute_r, dacMute_r, coreClear_r, slRamWe_r;
  logic [11:0] hostAddr, pinSetting_r;
  logic [15:0] hostWdata, hostRdata_r, v, pData = 16'h0000;
  logic [11:0] mpIn = 12'h000, pinExp = 12'h000;
  logic [15:0] auxIn = 16'h0F0F;
  logic [127:0] ifaceRegs_r;
  logic [63:0] auxData_r;
  logic [10:0] instrPerSample_r;
  logic [9:0] slRamAddr_r, sumA;
  logic [27:0] slRamData_r, sumD;
  int bad_count = 0, n_compared = 0, nWe;
  always #12.5 clk = ~clk;
  dcc_host_model dcc_host_model_inst (.clk, .hostRdata_r, .hostWr, .hostRd, .hostAddr,
    .hostWdata);
  dcc_core_control #(.CLK_HZ(HZ)) dcc_core_control_inst (.clk, .reset_n, .hostWr, .hostRd,
    .hostAddr, .hostWdata, .hostRdata_r, .progIfaceWe(pWe), .progIfaceIdx(3'h0),
    .progIfaceData(pData), .mpPins(mpIn), .auxAdcIn(auxIn), .ifaceRegs_r,
    .pinSetting_r, .auxData_r, .adcMute_r, .dacMute_r, .coreClear_r, .instrPerSample_r,
    .slRamWe_r, .slRamAddr_r, .slRamData_r);
  // Counts copied pairs and sums what they carry.
  always @(posedge clk) begin
    if (slRamWe_r === 1'b1)
      {nWe, sumA, sumD} <= {nWe + 1, sumA + slRamAddr_r, sumD + slRamData_r};
  end
  task wr(input logic [11:0] a, input logic [15:0] d);
    dcc_host_model_inst.wr(a, d);
  endtask
  task rd(input logic [11:0] a);
    dcc_host_model_inst.rd(a, v);
  endtask
  // Lets host writes settle, lets a program write pass one edge, then waits for effects.
  task prog(input logic [15:0] d);
    repeat (4) @(posedge clk);
    #1 pData = d;
    pWe = 1'b1;
    @(posedge clk);
    #1 pWe = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Changes the pins under one debounce code and brackets the cycle the new value lands.
  task deb(input logic [1:0] code, input int ms, input logic [11:0] pins);
    wr(CTL, {2'b00, code, 12'h01C});
    mpIn = pins;
    repeat (HZ / 1000 * ms - 8) @(posedge clk);
    #1 `CHK(pinSetting_r, pinExp)
    repeat (18) @(posedge clk);
    #1 `CHK(pinSetting_r, pins)
    pinExp = pins;
  endtask
  task tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run length.
  initial begin
    #(25 * 5000);
    bad_count++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    rd(CTL);
    `CHK(v, `DCC_CTRL_RESET)
    `CHK({adcMute_r, dacMute_r, coreClear_r}, 3'b111)
    `CHK(instrPerSample_r, `DCC_INSTR_1X)
    $display("reset test done");
    for (int r = 0; r < 4; r++) begin
      wr(CTL, 16'hFFDC | 16'(r));
      repeat (2) @(posedge clk);
      #1 `CHK(instrPerSample_r, r == 1 ? `DCC_INSTR_2X : r == 2 ? `DCC_INSTR_4X : `DCC_INSTR_1X)
      `CHK({adcMute_r, dacMute_r, coreClear_r}, 3'b000)
      rd(CTL);
      `CHK(v, 16'h31DC | 16'(r))
    end
    $display("rate test done");
    auxIn = 16'h1111;
    wr(12'h800, 16'h1234);
    wr(12'h808, 16'h0A5A);
    wr(12'h809, 16'hBEEF);
    wr(12'h80C, 16'hCAFE);
    prog(16'h5555);
    `CHK(ifaceRegs_r[15:0], 16'h1234)
    `CHK(pinSetting_r, 12'hA5A)
    `CHK(auxData_r, {16'hCAFE, 32'h0F0F_0F0F, 16'hBEEF})
    wr(CTL, 16'h001C);
    wr(12'h800, 16'h7777);
    prog(16'h5555);
    `CHK(ifaceRegs_r[15:0], 16'h5555)
    `CHK(auxData_r, {4{16'h1111}})
    $display("override test done");
    deb(2'b00, `DCC_DEB_MS_00, 12'h3C5);
    deb(2'b01, `DCC_DEB_MS_01, 12'h0A0);
    deb(2'b10, `DCC_DEB_MS_10, 12'h5F3);
    deb(2'b11, `DCC_DEB_MS_11, 12'hC0C);
    wr(CTL, 16'h309C);
    wr(12'h808, 16'h0123);
    mpIn = 12'h456;
    repeat (40) @(posedge clk);
    #1 `CHK(pinSetting_r, 12'h123)
    $display("debounce test done");
    wr(12'h810, 16'h0007);
    wr(12'h815, 16'h0012);
    wr(12'h813, 16'h8001);
    wr(12'h818, 16'h0155);
    {nWe, sumA, sumD} = 0;
    wr(CTL, 16'h003C);
    rd(CTL);
    `CHK(v[5], 1'b1)
    dcc_host_model_inst.wait_idle(ok);
    repeat (2) @(posedge clk);
    #1 `CHK(ok, 1'b1)
    `CHK({nWe, sumA, sumD}, {32'd2, 10'h167, 28'hFFF8008})
    wr(12'h814, 16'h0001);
    wr(12'h819, 16'h0003);
    {nWe, sumA, sumD} = 0;
    wr(CTL, 16'h003C);
    dcc_host_model_inst.wait_idle(ok);
    repeat (2) @(posedge clk);
    #1 `CHK({ok, nWe, sumA, sumD}, {1'b1, 32'd1, 10'h003, 28'h0000001})
    rd(CTL);
    `CHK(v[5], 1'b0)
    $display("safeload test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
